// ===== dac_clock_consts.vh
`ifndef DAC_CLOCK_CONSTS_VH
`define DAC_CLOCK_CONSTS_VH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define IDX_CTRL0        3'h0
`define IDX_PIN_FUNC     3'h1
`define IDX_CLK_MODE     3'h2
`define IDX_PIN_ROUTE    3'h3
`define IDX_RATE_CFG     3'h4

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define BIT_LOCK_STAT    1
`define BIT_SLEEP        3
`define BIT_PDOWN        4
`define BIT_FUNC_CLK     0
`define BIT_PLL_EN       7
`define BIT_ONE_PORT     6
`define BIT_DCLK_INV     4
`define BIT_OCLK_INV     2
`define BIT_IQ_INV       1
`define BIT_ROUTE_SDO    7
`define LSB_INTERP       0
`define BIT_ZERO_STUFF   2
`define LSB_PRESCALE     3

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define RST_BYTE         8'h00
`define CLK_PERIOD_NS    10
`define LOCK_TIME_NS     10000
`define LOCK_CYCLES      (`LOCK_TIME_NS / `CLK_PERIOD_NS)

`endif

// ===== dac_clock_ctrl.v
`timescale 1ns/1ps
`default_nettype none
`include "dac_clock_consts.vh"

module dac_clock_ctrl #(
  parameter LOCK_CYCLES = `LOCK_CYCLES,
  parameter DW          = 14
) (
  // Clock, reset and enable.
  input  wire          CORE_CLK,
  input  wire          RST_N,
  input  wire          CE,
  // Register port.
  input  wire [4:0]    ADDR,
  input  wire [7:0]    WDATA,
  input  wire          WR,
  input  wire          RD,
  output reg  [7:0]    RDATA,
  // Sample ports.
  input  wire [DW-1:0] PORT_A,
  input  wire [DW-1:0] PORT_B,
  input  wire          PORT_B_BIT14,
  output reg           PORT_B_BIT15_O,
  output reg           PORT_B_BIT15_OE,
  // Clock and lock pins.
  output reg           SHARED_CLOCK_LOCK_PIN,
  output reg           SDO_O,
  output reg           SDO_OE,
  // Internal clocking and channel outputs.
  output reg  [3:0]    CLK_EN,
  output reg  [7:0]    OSC_MULT,
  output reg           DAC_CURRENT_EN,
  output reg           LOCKED,
  output reg  [DW-1:0] CH_I,
  output reg  [DW-1:0] CH_Q,
  output reg           CH_VALID
);

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  // Five byte-wide control registers; all clear to the reset byte.
  reg [7:0] ctrl0_q;
  reg [7:0] func_q;
  reg [7:0] mode_q;
  reg [7:0] route_q;
  reg [7:0] rate_q;

  // Field views of the control bytes. Bit 1 of the first byte is
  // written like any other bit but is replaced by the lock flag on
  // reads, so software can never fake a lock.
  wire       sleep     = ctrl0_q[`BIT_SLEEP];
  wire       pdown     = ctrl0_q[`BIT_PDOWN];
  wire       pll_en    = mode_q[`BIT_PLL_EN];
  wire       one_port  = mode_q[`BIT_ONE_PORT];
  wire       dclk_inv  = mode_q[`BIT_DCLK_INV];
  wire       oclk_inv  = mode_q[`BIT_OCLK_INV];
  wire       iq_inv    = mode_q[`BIT_IQ_INV];
  wire       to_sdo    = route_q[`BIT_ROUTE_SDO];
  wire       fn_clk    = func_q[`BIT_FUNC_CLK];
  wire [1:0] interp    = rate_q[`LSB_INTERP +: 2];
  wire       zstuff    = rate_q[`BIT_ZERO_STUFF];
  wire [1:0] prescale  = rate_q[`LSB_PRESCALE +: 2];
  // Only aligned addresses hit; the two low bits must be zero.
  wire       wr_hit    = WR && (ADDR[1:0] == 2'h0);

  // Register writes; power-down leaves this port alive.
  // A write with the enable low is dropped, like every other update.
  always @(posedge CORE_CLK) begin
    if (!RST_N) begin
      ctrl0_q <= `RST_BYTE;
      func_q  <= `RST_BYTE;
      mode_q  <= `RST_BYTE;
      route_q <= `RST_BYTE;
      rate_q  <= `RST_BYTE;
    end else if (CE && wr_hit) begin
      case (ADDR[4:2])
        `IDX_CTRL0:     ctrl0_q <= WDATA;
        `IDX_PIN_FUNC:  func_q  <= WDATA;
        `IDX_CLK_MODE:  mode_q  <= WDATA;
        `IDX_PIN_ROUTE: route_q <= WDATA;
        `IDX_RATE_CFG:  rate_q  <= WDATA;
        default: ;
      endcase
    end
  end

  // Read data one cycle after the strobe; unmapped reads give zero.
  // The lock bit is merged at read time so that it is never stale.
  always @(posedge CORE_CLK) begin
    if (!RST_N) begin
      RDATA <= 8'h00;
    end else if (CE) begin
      RDATA <= 8'h00;
      if (RD && ADDR[1:0] == 2'h0) begin
        case (ADDR[4:2])
          `IDX_CTRL0: begin
            RDATA <= ctrl0_q;
            RDATA[`BIT_LOCK_STAT] <= LOCKED;
          end
          `IDX_PIN_FUNC:  RDATA <= func_q;
          `IDX_CLK_MODE:  RDATA <= mode_q;
          `IDX_PIN_ROUTE: RDATA <= route_q;
          `IDX_RATE_CFG:  RDATA <= rate_q;
          default:        RDATA <= 8'h00;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Rate divider
  // ----------------------------------------------------------------
  // One-port has no 1x interpolation, so it is raised to 2x here
  // rather than leaving the sample-rate clock without an edge.
  wire [1:0] interp_eff = (one_port && interp == 2'h0) ? 2'h1 : interp;
  wire [2:0] shift      = {1'b0, interp_eff} + {2'h0, zstuff};
  wire [4:0] ratio      = 5'h01 << shift;
  wire [4:0] half       = {1'b0, ratio[4:1]};
  wire [4:0] half_up    = {1'b0, ratio[4:1]} + {4'h0, ratio[0]};
  wire       run        = CE && !pdown;

  // The counter runs from zero to R-1; a ratio of one keeps it at zero,
  // so every core edge is then a sample-rate edge.
  reg  [3:0] cnt_q;
  wire [4:0] cnt_w = {1'b0, cnt_q};
  wire       wrap  = (cnt_w == ratio - 5'h01);

  // The core clock is the fastest internal clock in both PLL modes;
  // the sample rate is it divided by interpolation and stuffing.
  always @(posedge CORE_CLK) begin
    if (!RST_N) begin
      cnt_q <= 4'h0;
    end else if (run) begin
      cnt_q <= wrap ? 4'h0 : cnt_q + 4'h1;
    end
  end

  // The sample strobe marks the start of each period; the interleaved
  // strobe adds the midpoint. Both pin clocks are high in the first
  // half of their period, rounded up so that odd halves stay high longer.
  wire stb    = run && (cnt_q == 4'h0);
  wire il_stb = run && (cnt_q == 4'h0 || cnt_w == half);
  wire [4:0] il_pos  = (cnt_w >= half) ? cnt_w - half : cnt_w;
  wire [4:0] il_up   = {1'b0, half[4:1]} + {4'h0, half[0]};
  wire       rate_ck = (cnt_w < half_up);
  wire       il_ck   = (il_pos < il_up);

  // ----------------------------------------------------------------
  // Internal 1x/2x/4x/8x clock enables
  // ----------------------------------------------------------------
  // A free-running three-bit count spaces the four clock enables.
  // It stops in power-down, and the enables are held low with it.
  reg  [2:0] free_q;
  wire [3:0] en_d;

  always @(posedge CORE_CLK) begin
    if (!RST_N) begin
      free_q <= 3'h0;
    end else if (run) begin
      free_q <= free_q + 3'h1;
    end
  end

  // Bit 0 is the 1x enable, bit 3 the 8x enable.
  // All four pulse together once in every eight running cycles.
  genvar k;
  generate
    for (k = 0; k < 4; k = k + 1) begin : g_en
      wire [2:0] mask = 3'h7 >> k;
      assign en_d[k] = run && ((free_q & mask) == mask);
    end
  endgenerate

  // ----------------------------------------------------------------
  // Lock tracking
  // ----------------------------------------------------------------
  // The lock flag models the acquisition time: a plain count of
  // enabled cycles stands in for the analogue loop settling.
  reg [15:0] lock_cnt_q;

  // Lock is lost at once when the PLL is disabled or powered down.
  always @(posedge CORE_CLK) begin
    if (!RST_N) begin
      lock_cnt_q <= 16'h0000;
      LOCKED     <= 1'b0;
    end else if (CE) begin
      if (!pll_en || pdown) begin
        lock_cnt_q <= 16'h0000;
        LOCKED     <= 1'b0;
      end else if (lock_cnt_q < LOCK_CYCLES[15:0] - 16'h0001) begin
        lock_cnt_q <= lock_cnt_q + 16'h0001;
      end else begin
        LOCKED <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Clock status outputs and pins
  // ----------------------------------------------------------------
  // With the PLL on and the function bit low the lock flag is shown;
  // in every other case the sample-rate clock is, after its invert.
  // The shared pin is held low when not routed; the serial pin is released, its enable low.
  wire pin_sig = (pll_en && !fn_clk) ? LOCKED : (rate_ck ^ dclk_inv);

  always @(posedge CORE_CLK) begin
    if (!RST_N) begin
      CLK_EN                <= 4'h0;
      OSC_MULT              <= 8'h00;
      DAC_CURRENT_EN        <= 1'b0;
      SHARED_CLOCK_LOCK_PIN <= 1'b0;
      SDO_O                 <= 1'b0;
      SDO_OE                <= 1'b0;
      PORT_B_BIT15_O        <= 1'b0;
      PORT_B_BIT15_OE       <= 1'b0;
    end else if (CE) begin
      CLK_EN <= en_d;
      // Without the PLL there is no oscillator, so zero is shown.
      OSC_MULT <= pll_en ? (8'h01 << (shift + {1'b0, prescale}))
                         : 8'h00;
      // Sleep only gates the currents; the rest keeps running.
      DAC_CURRENT_EN <= !sleep && !pdown;
      if (run) begin
        SHARED_CLOCK_LOCK_PIN <= to_sdo ? 1'b0 : pin_sig;
        SDO_O                 <= to_sdo ? pin_sig : 1'b0;
        SDO_OE                <= to_sdo;
        PORT_B_BIT15_O        <= one_port ? (il_ck ^ oclk_inv) : 1'b0;
        PORT_B_BIT15_OE       <= one_port;
      end
    end
  end

  // ----------------------------------------------------------------
  // Sample capture
  // ----------------------------------------------------------------
  // The select input is taken on the same edge as the sample, so a
  // source that changes both together never splits a pair.
  reg [DW-1:0] i_hold_q;
  reg [DW-1:0] q_hold_q;
  wire         to_second = PORT_B_BIT14 ^ iq_inv;

  // One-port fills two holding registers on interleaved edges and
  // hands the pair over on each channel-rate edge.
  always @(posedge CORE_CLK) begin
    if (!RST_N) begin
      i_hold_q <= {DW{1'b0}};
      q_hold_q <= {DW{1'b0}};
    end else if (one_port && il_stb) begin
      if (to_second) begin
        q_hold_q <= PORT_A;
      end else begin
        i_hold_q <= PORT_A;
      end
    end
  end

  // Channel I and Q change only on the sample-rate edge.
  // In one-port mode the holds lag by one period, which costs a
  // period of latency but keeps I and Q of a pair aligned.
  always @(posedge CORE_CLK) begin
    if (!RST_N) begin
      CH_I     <= {DW{1'b0}};
      CH_Q     <= {DW{1'b0}};
      CH_VALID <= 1'b0;
    end else if (CE) begin
      CH_VALID <= stb;
      if (stb) begin
        if (one_port) begin
          CH_I <= i_hold_q;
          CH_Q <= q_hold_q;
        end else begin
          CH_I <= PORT_A;
          CH_Q <= PORT_B;
        end
      end
    end
  end

endmodule

`default_nettype wire

// ===== dac_clock_ctrl_chk.sv
`timescale 1ns/1ps
`default_nettype none
module dac_clock_ctrl_chk #(
  parameter LOCK_CYCLES = 8,
  parameter DW          = 14
) (
  // Clock and reset.
  input wire logic       CORE_CLK,
  input wire logic       RST_N,
  // Register port.
  input wire logic       WR,
  input wire logic       RD,
  input wire logic [7:0] RDATA,
  // Pins and status.
  input wire logic       PORT_B_BIT15_OE,
  input wire logic       SHARED_CLOCK_LOCK_PIN,
  input wire logic       SDO_O,
  input wire logic       SDO_OE,
  input wire logic [3:0] CLK_EN,
  input wire logic [7:0] OSC_MULT,
  input wire logic       LOCKED
);
  // One clock domain, so clocking and reset are stated once.
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  a_rdata_idle: assert property (!$past(RD) |-> RDATA == 8'h00)
    else $error("read data outside its cycle");
  a_pin_excl: assert property (SDO_OE |-> !SHARED_CLOCK_LOCK_PIN)
    else $error("both clock pins driven");
  a_sdo_idle: assert property (!SDO_OE |-> !SDO_O)
    else $error("serial pin driven while unrouted");
  a_osc_power: assert property ($onehot0(OSC_MULT))
    else $error("oscillator ratio not a power of two");
  a_lock_osc: assert property ($rose(LOCKED) |-> OSC_MULT != 8'h00)
    else $error("lock without running oscillator");
  a_lock_wait: assert property ($rose(OSC_MULT != 8'h00) |-> !LOCKED [*4])
    else $error("lock without acquisition");
  a_clken_sync: assert property (CLK_EN[0] |-> CLK_EN[2:1] == 2'b11)
    else $error("clock enables not aligned");
  a_oe_hold: assert property (!$past(WR) && !$past(WR, 2) |-> $stable(PORT_B_BIT15_OE))
    else $error("interleaved enable moved without a write");
  c_locked: cover property ($rose(LOCKED));
  c_sdo_lock: cover property (SDO_OE && SDO_O);
  c_one_port: cover property (PORT_B_BIT15_OE && CLK_EN[0]);
endmodule
bind dac_clock_ctrl dac_clock_ctrl_chk #(.LOCK_CYCLES(LOCK_CYCLES), .DW(DW)) chk_i (
  .CORE_CLK(CORE_CLK), .RST_N(RST_N), .WR(WR), .RD(RD), .RDATA(RDATA),
  .PORT_B_BIT15_OE(PORT_B_BIT15_OE), .SHARED_CLOCK_LOCK_PIN(SHARED_CLOCK_LOCK_PIN),
  .SDO_O(SDO_O), .SDO_OE(SDO_OE), .CLK_EN(CLK_EN), .OSC_MULT(OSC_MULT), .LOCKED(LOCKED));
`default_nettype wire

// ===== sample_source.sv
`timescale 1ns/1ps
`default_nettype none
module sample_source #(parameter int DW = 14) (
  // Clock and next values.
  input  wire logic          clk,
  input  wire logic [DW-1:0] a_in,
  input  wire logic [DW-1:0] b_in,
  input  wire logic          sel_in,
  // Sample port pins.
  output var  logic [DW-1:0] port_a = '0,
  output var  logic [DW-1:0] port_b = '0,
  output var  logic          sel = 1'b0
);
  // Registered, so a value held by the bench stays whole across capture edges.
  always @(posedge clk) begin
    port_a <= a_in;
    port_b <= b_in;
    sel <= sel_in;
  end
endmodule
`default_nettype wire

// ===== dac_clock_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none
module dac_clock_ctrl_bench;
  logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, sel = 1'b0, ce = 1'b1;
  logic [4:0]  addr = 5'h00;
  logic [7:0]  wdata = 8'h00, rdata, osc, r;
  logic [13:0] a = 14'h0000, b = 14'h0000, x, y, pa, pb, ci, cq;
  logic [3:0]  cen;
  logic        bs, b15, b15_oe, pin, sdo, sdo_oe, cur, lock, vld;
  int          n_mismatch = 0, tests_run = 0, i, e0, e1, nv, c1, c8;
  // Core clock, 100 MHz.
  always #5 clk = ~clk;
  sample_source src (.clk(clk), .a_in(a), .b_in(b), .sel_in(sel), .port_a(pa), .port_b(pb),
    .sel(bs));
  // Clock enable is driven by the bench; one scenario drops it.
  dac_clock_ctrl #(.LOCK_CYCLES(8)) uut (.CORE_CLK(clk), .RST_N(rst_n), .CE(ce), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .PORT_A(pa), .PORT_B(pb), .PORT_B_BIT14(bs),
    .PORT_B_BIT15_O(b15), .PORT_B_BIT15_OE(b15_oe), .SHARED_CLOCK_LOCK_PIN(pin), .SDO_O(sdo),
    .SDO_OE(sdo_oe), .CLK_EN(cen), .OSC_MULT(osc), .DAC_CURRENT_EN(cur), .LOCKED(lock),
    .CH_I(ci), .CH_Q(cq), .CH_VALID(vld));
  task automatic chk(input string what, input logic [13:0] exp, input logic [13:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr8(input logic [4:0] ad, input logic [7:0] d);
    @(posedge clk);
    addr <= ad;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe.
  task automatic rd8(input logic [4:0] ad, input logic [7:0] exp);
    @(posedge clk);
    addr <= ad;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk("rdata", 14'(exp), 14'(rdata));
  endtask
  // A strobe that never comes ends the run rather than hanging it.
  task automatic wait_vld;
    for (int k = 0; k < 64; k++) begin
      tick(1);
      if (vld === 1'b1)
        return;
    end
    n_mismatch++;
    stop_test();
  endtask
  task automatic put(input logic [13:0] va, input logic [13:0] vb, input logic s);
    @(posedge clk);
    a <= va;
    b <= vb;
    sel <= s;
    tick(8);
  endtask
  // Counts edges on the rate and interleaved clocks and strobes over 16 cycles.
  task automatic meas;
    logic p, q;
    {e0, e1, nv, c1, c8} = '0;
    repeat (16) begin
      p = pin;
      q = b15;
      tick(1);
      e0 += int'(pin != p);
      e1 += int'(b15 != q);
      nv += int'(vld);
      c1 += int'(cen[0]);
      c8 += int'(cen[3]);
    end
  endtask
  function automatic logic [13:0] osc_exp(input logic [7:0] c);
    return 14'h0001 << (int'(c[1:0]) + int'(c[2]) + int'(c[4:3]));
  endfunction
  initial begin
    void'($urandom(32'hB3864232));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    for (i = 0; i < 7; i++)
      rd8((i < 6) ? 5'(4 * i) : 5'h01, 8'h00);
    wr8(5'h08, 8'h80);
    for (i = 0; i < 3; i++) begin
      r = 8'($urandom % 32);
      wr8(5'h10, r);
      tick(12);
      chk("osc", osc_exp(r), 14'(osc));
      chk("lock", 14'h0001, 14'(lock));
      rd8(5'h00, 8'h02);
    end
    wr8(5'h10, 8'h08);
    tick(2);
    chk("osc div2", osc_exp(8'h08), 14'(osc));
    chk("lock pin", 14'h0001, 14'(pin));
    wr8(5'h0C, 8'h80);
    tick(2);
    chk("sdo lock", 14'h0006, 14'({sdo_oe, sdo, pin}));
    wr8(5'h08, 8'h00);
    wr8(5'h10, 8'h01);
    tick(3);
    chk("pll off", 14'h0000, 14'({lock, osc}));
    meas();
    chk("pin idle", 14'h0000, 14'(e0));
    wr8(5'h0C, 8'h00);
    tick(2);
    meas();
    chk("rate edges", 14'h0010, 14'(e0));
    chk("strobes", 14'h0008, 14'(nv));
    chk("1x enables", 14'h0002, 14'(c1));
    chk("8x enables", 14'h0010, 14'(c8));
    x = 14'($urandom);
    y = 14'($urandom);
    put(x, y, 1'b0);
    wait_vld();
    chk("port a", x, ci);
    chk("port b", y, cq);
    wr8(5'h10, 8'h02);
    for (i = 0; i < 2; i++) begin
      wr8(5'h08, (i != 0) ? 8'h42 : 8'h40);
      x = 14'($urandom);
      y = 14'($urandom);
      put(x, 14'h0000, 1'b0);
      put(y, 14'h0000, 1'b1);
      wait_vld();
      chk("chan i", (i != 0) ? y : x, ci);
      chk("chan q", (i != 0) ? x : y, cq);
    end
    chk("oe", 14'h0001, 14'(b15_oe));
    meas();
    chk("il edges", 14'h0010, 14'(e1));
    chk("rate edges", 14'h0008, 14'(e0));
    // With the enable low every pin holds its level.
    @(posedge clk);
    ce <= 1'b0;
    #1;
    meas();
    @(posedge clk);
    ce <= 1'b1;
    chk("frozen rate pin", 14'h0000, 14'(e0));
    chk("frozen il pin", 14'h0000, 14'(e1));
    wr8(5'h00, 8'h08);
    tick(3);
    chk("sleep", 14'h0000, 14'(cur));
    meas();
    chk("sleep strobes", 14'h0004, 14'(nv));
    wr8(5'h00, 8'h00);
    tick(2);
    chk("awake", 14'h0001, 14'(cur));
    wr8(5'h00, 8'h10);
    tick(2);
    meas();
    chk("pdown strobes", 14'h0000, 14'(nv));
    rd8(5'h00, 8'h10);
    // Leave power-down and let the divider run 16 cycles before measuring.
    wr8(5'h00, 8'h00);
    tick(16);
    meas();
    chk("wake strobes", 14'h0004, 14'(nv));
    stop_test();
  end
endmodule
`default_nettype wire
